// [core/debug_pin_mux.sv]
// Debug status routing onto the four port pins
`timescale 1ns/1ns
module debug_pin_mux (
	input wire logic clock_in, // System clock
	input wire logic rst_in, // Synchronous reset
	input wire logic [3:0] status_in, // Status lanes
	input wire radio_pkg::debug_cfg_t cfg_in, // Enables and polarity
	output radio_pkg::dbg_pins_t pins_out // Pin levels and enables
);
	import radio_pkg::*;

	dbg_pins_t st_r;
	dbg_pins_t st_nxt;

	always_comb begin
		st_nxt.level = status_in ^ cfg_in.pol;
		st_nxt.oe = cfg_in.oe;
	end

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign pins_out = st_r;

	AST_DBG_POLARITY: assert property (@(posedge clock_in)
		disable iff (rst_in)
		1'b1 |=> pins_out.level == $past(status_in ^ cfg_in.pol))
		else $error("Debug pin level ignores polarity");

endmodule : debug_pin_mux

// [core/radio_status_ctl.sv]
// Radio status, crystal trim, debug routing and regulator control
// ---------------------------------------------------------------
// Notes on behaviour
// - Chip identification reads a fixed byte; writes have no effect.
// - Status bit 4 follows transmit activity.
// - Status bit 3 is high while the receive queue holds bytes.
// - Status bit 2 is high when queue count exceeds threshold level.
// - With filtering on, bit 2 waits until the frame passed filtering.
// - A complete received frame also raises bit 2.
// - Status bit 1 follows the live frame delimiter indication.
// - Four-bit crystal trim, reset all ones; 0000 adds most load.
// - Acknowledge frames raise the radio flag only when enabled; below the minimum revision they always raise it.
// - Trim and acknowledge enable exist only from a minimum revision.
// - Four status bits can be routed to port 1 pins 4 to 7.
// - Three pin configuration registers select the debug routing.
// - Power-down bit one disables analog regulator; clearing starts it.
// - Analog regulator is enabled only after a programmable delay.
// - Regulator ready flag sets when that delay expires.
// - A pollable status bit shows the regulator still powered down.
// - Digital regulator is off in the two deepest sleep modes.
// - Seven-bit threshold level, reset 0x40.
// - Debug pins drive only when enabled, XORed with polarity.
// ---------------------------------------------------------------
`timescale 1ns/1ns
module radio_status_ctl #(
	// Arbitrary values, not tied to any real part
	parameter logic [7:0] CHIP_ID = 8'h5a,
	parameter logic [7:0] CHIP_REVISION = 8'h11,
	parameter logic [7:0] MIN_REVISION = 8'h10
) (
	input wire logic clock_in, // System clock, 10 MHz
	input wire logic rst_in, // Synchronous reset, high
	input wire radio_pkg::bus_req_t bus_in, // Register access
	output logic [7:0] rdata_out, // Read data, cycle after read
	input wire radio_pkg::radio_evt_t radio_in, // Radio core state
	input wire logic [1:0] power_mode_in, // Current power mode
	output radio_pkg::dbg_pins_t dbg_pins_out, // Port 1 pins 4..7
	output logic [3:0] xtal_trim_out, // Crystal load trim code
	output logic analog_reg_enable_out, // Analog regulator on
	output logic digital_reg_enable_out, // Digital regulator on
	output logic [1:0] radio_flags_out // Ack and ready flags
);
	import radio_pkg::*;

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [6:0] thr;
		logic [7:0] cfg_a;
		logic [7:0] cfg_b;
		logic [5:0] cfg_c;
		logic [3:0] trim;
		logic ack_en;
		logic pd;
		logic [3:0] delay;
		reg_state_t rs;
		logic [7:0] cnt;
		logic [1:0] flags;
		logic dig_en;
		logic [7:0] rdata;
	} state_t;

	localparam state_t ST_RESET = '{
		thr: RST_THRESHOLD,
		cfg_a: 8'h00,
		cfg_b: 8'h00,
		cfg_c: 6'h00,
		trim: RST_XTAL_TRIM,
		ack_en: RST_ACK_EN,
		pd: RST_POWERDOWN,
		delay: RST_PWR_DELAY,
		rs: REG_OFF,
		cnt: 8'h00,
		flags: 2'h0,
		dig_en: 1'b1,
		rdata: 8'h00
	};

	// Older revisions lack the trim and ack enable registers
	localparam logic HAS_EXT = CHIP_REVISION >= MIN_REVISION;

	state_t st_r;
	state_t st_nxt;

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	function automatic logic hit(input logic [15:0] a,
		input logic [15:0] ofs);
		hit = a == ofs;
	endfunction : hit

	function automatic logic [7:0] delay_load(input logic [3:0] d);
		delay_load = 8'(({4'h0, d} + 8'h01) * 8'(DELAY_STEP_CYC));
	endfunction : delay_load

	// Only multiplexer setting zero passes the status signal out
	function automatic logic sel_ok(input logic [7:0] cfg);
		sel_ok = cfg[4:0] == 5'h00;
	endfunction : sel_ok

	logic wr_hit;
	logic thresh;
	logic [7:0] status_byte;
	logic [3:0] dbg_lanes;
	debug_cfg_t dbg_cfg;

	// ---------------------------------------------------------------
	// Status composition
	// ---------------------------------------------------------------
	always_comb begin
		thresh = (radio_in.rx_count > {1'b0, st_r.thr})
			&& (!radio_in.filter_en || radio_in.frame_passed);
		thresh = thresh || radio_in.frame_complete;
		status_byte = 8'h00;
		status_byte[ST_TX_ACTIVE] = radio_in.tx_active;
		status_byte[ST_RX_DATA] = radio_in.rx_count != 8'h00;
		status_byte[ST_RX_THRESH] = thresh;
		status_byte[ST_SFD] = radio_in.frame_delimiter_status;
		status_byte[ST_CCA] = radio_in.cca;
	end

	// ---------------------------------------------------------------
	// Debug routing
	// ---------------------------------------------------------------
	always_comb begin
		dbg_lanes[DBG_RX_DATA] = status_byte[ST_RX_DATA];
		dbg_lanes[DBG_RX_THRESH] = status_byte[ST_RX_THRESH];
		dbg_lanes[DBG_SFD] = status_byte[ST_SFD];
		dbg_lanes[DBG_CCA] = status_byte[ST_CCA];
		dbg_cfg.oe[DBG_RX_DATA] = st_r.cfg_c[CFG_C_OE_DATA];
		dbg_cfg.pol[DBG_RX_DATA] = st_r.cfg_c[CFG_C_POL_DATA];
		dbg_cfg.oe[DBG_RX_THRESH] = st_r.cfg_c[CFG_C_OE_THR];
		dbg_cfg.pol[DBG_RX_THRESH] = st_r.cfg_c[CFG_C_POL_THR];
		dbg_cfg.oe[DBG_SFD] = st_r.cfg_b[CFG_OE_BIT]
			&& sel_ok(st_r.cfg_b);
		dbg_cfg.pol[DBG_SFD] = st_r.cfg_b[CFG_POL_BIT];
		dbg_cfg.oe[DBG_CCA] = st_r.cfg_a[CFG_OE_BIT]
			&& sel_ok(st_r.cfg_a);
		dbg_cfg.pol[DBG_CCA] = st_r.cfg_a[CFG_POL_BIT];
	end

	debug_pin_mux u_dbg (
		.clock_in(clock_in),
		.rst_in(rst_in),
		.status_in(dbg_lanes),
		.cfg_in(dbg_cfg),
		.pins_out(dbg_pins_out)
	);

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		wr_hit = bus_in.wr;

		// Register writes
		if (wr_hit) begin
			if (hit(bus_in.addr, OFS_RX_THRESHOLD)) begin
				st_nxt.thr = bus_in.wdata[6:0];
			end
			if (hit(bus_in.addr, OFS_PIN_CFG_A)) begin
				st_nxt.cfg_a = {1'b0, bus_in.wdata[6:0]};
			end
			if (hit(bus_in.addr, OFS_PIN_CFG_B)) begin
				st_nxt.cfg_b = {1'b0, bus_in.wdata[6:0]};
			end
			if (hit(bus_in.addr, OFS_PIN_CFG_C)) begin
				st_nxt.cfg_c = bus_in.wdata[5:0];
			end
			if (HAS_EXT && hit(bus_in.addr, OFS_XTAL_TRIM)) begin
				st_nxt.trim = bus_in.wdata[3:0];
			end
			if (HAS_EXT && hit(bus_in.addr, OFS_IRQ_SRC_EN)) begin
				st_nxt.ack_en = bus_in.wdata[0];
			end
			if (hit(bus_in.addr, OFS_POWER_CTL)) begin
				st_nxt.pd = bus_in.wdata[PWR_PD_BIT];
				st_nxt.delay = bus_in.wdata[PWR_DELAY_LSB +: 4];
			end
			if (hit(bus_in.addr, OFS_IRQ_FLAGS)) begin
				// Write one to clear
				st_nxt.flags = st_r.flags & ~bus_in.wdata[1:0];
			end
		end

		// Analog regulator delayed power-on
		case (st_r.rs)
			REG_OFF: begin
				if (!st_r.pd) begin
					st_nxt.rs = REG_WAIT;
					st_nxt.cnt = delay_load(st_r.delay);
				end
			end
			REG_WAIT: begin
				if (st_r.pd) begin
					st_nxt.rs = REG_OFF;
				end else if (st_r.cnt <= 8'h01) begin
					st_nxt.rs = REG_ON;
					st_nxt.flags[IRQ_REG_READY_BIT] = 1'b1;
				end else begin
					st_nxt.cnt = st_r.cnt - 8'h01;
				end
			end
			REG_ON: begin
				if (st_r.pd) begin
					st_nxt.rs = REG_OFF;
				end
			end
			default: begin
				st_nxt.rs = REG_OFF;
			end
		endcase

		// Set wins over a clear in the same cycle
		if (radio_in.ack_frame && (st_r.ack_en || !HAS_EXT)) begin
			st_nxt.flags[IRQ_ACK_BIT] = 1'b1;
		end

		// Registers and RAM keep state; only the supply is switched
		st_nxt.dig_en = !(power_mode_in == SLEEP_MODE_TWO
			|| power_mode_in == SLEEP_MODE_THREE);

		// Read data, valid in the cycle after the strobe
		st_nxt.rdata = 8'h00;
		if (bus_in.rd) begin
			case (bus_in.addr)
				OFS_RX_THRESHOLD: st_nxt.rdata = {1'b0, st_r.thr};
				OFS_PIN_CFG_A: st_nxt.rdata = st_r.cfg_a;
				OFS_PIN_CFG_B: st_nxt.rdata = st_r.cfg_b;
				OFS_PIN_CFG_C: st_nxt.rdata = {2'h0, st_r.cfg_c};
				OFS_CHIP_REVISION: st_nxt.rdata = CHIP_REVISION;
				OFS_CHIP_ID: st_nxt.rdata = CHIP_ID;
				OFS_RADIO_STATUS: st_nxt.rdata = status_byte;
				OFS_XTAL_TRIM: begin
					st_nxt.rdata = HAS_EXT ? {4'h0, st_r.trim} : 8'h00;
				end
				OFS_IRQ_SRC_EN: begin
					st_nxt.rdata = {7'h00, HAS_EXT && st_r.ack_en};
				end
				OFS_POWER_CTL: begin
					st_nxt.rdata = {st_r.delay, 2'h0, st_r.pd,
						st_r.rs != REG_ON};
				end
				OFS_IRQ_FLAGS: st_nxt.rdata = {6'h00, st_r.flags};
				default: st_nxt.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			st_r <= ST_RESET;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign rdata_out = st_r.rdata;
	assign xtal_trim_out = st_r.trim;
	assign analog_reg_enable_out = st_r.rs == REG_ON;
	assign digital_reg_enable_out = st_r.dig_en;
	assign radio_flags_out = st_r.flags;

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	localparam int MAX_WAIT = 170;

	sequence s_pd_cleared;
		st_r.rs == REG_OFF && !st_r.pd;
	endsequence

	sequence s_waiting;
		st_r.rs == REG_WAIT && !st_r.pd;
	endsequence

	property p_power_on_bounded;
		@(posedge clock_in) disable iff (rst_in)
		s_pd_cleared ##1 s_waiting |->
			##[1:MAX_WAIT] (st_r.flags[IRQ_REG_READY_BIT] || st_r.pd);
	endproperty

	property p_power_on_not_early;
		@(posedge clock_in) disable iff (rst_in)
		s_pd_cleared ##1 s_waiting |->
			(!analog_reg_enable_out || st_r.pd)[*8];
	endproperty

	AST_CHIP_ID_FIXED: assert property (@(posedge clock_in)
		disable iff (rst_in)
		bus_in.rd && bus_in.addr == OFS_CHIP_ID |=> rdata_out == CHIP_ID)
		else $error("Chip identification read wrong");

	AST_TX_ACTIVE_BIT: assert property (@(posedge clock_in)
		disable iff (rst_in)
		bus_in.rd && bus_in.addr == OFS_RADIO_STATUS |=>
			rdata_out[ST_TX_ACTIVE] == $past(radio_in.tx_active))
		else $error("Transmit active bit wrong");

	AST_RX_DATA_BIT: assert property (@(posedge clock_in)
		disable iff (rst_in)
		bus_in.rd && bus_in.addr == OFS_RADIO_STATUS |=>
			rdata_out[ST_RX_DATA] == ($past(radio_in.rx_count) != 8'h00))
		else $error("Receive data bit wrong");

	AST_THRESH_HOLDS_BACK: assert property (@(posedge clock_in)
		disable iff (rst_in)
		bus_in.rd && bus_in.addr == OFS_RADIO_STATUS
			&& radio_in.filter_en && !radio_in.frame_passed
			&& !radio_in.frame_complete |=> !rdata_out[ST_RX_THRESH])
		else $error("Threshold flag before filtering passed");

	AST_THRESH_AT_LEVEL: assert property (@(posedge clock_in)
		disable iff (rst_in)
		bus_in.rd && bus_in.addr == OFS_RADIO_STATUS
			&& radio_in.rx_count <= {1'b0, st_r.thr}
			&& !radio_in.frame_complete |=> !rdata_out[ST_RX_THRESH])
		else $error("Threshold flag at or below level");

	AST_SFD_BIT: assert property (@(posedge clock_in)
		disable iff (rst_in)
		bus_in.rd && bus_in.addr == OFS_RADIO_STATUS |=>
			rdata_out[ST_SFD] == $past(radio_in.frame_delimiter_status))
		else $error("Frame delimiter bit wrong");

	AST_TRIM_RESET: assert property (@(posedge clock_in)
		rst_in |=> xtal_trim_out == RST_XTAL_TRIM)
		else $error("Crystal trim reset value wrong");

	AST_ACK_MASKED: assert property (@(posedge clock_in)
		disable iff (rst_in)
		HAS_EXT && radio_in.ack_frame && !st_r.ack_en
			&& !st_r.flags[IRQ_ACK_BIT] |=> !radio_flags_out[IRQ_ACK_BIT])
		else $error("Masked acknowledge frame set flag");

	AST_PD_DISABLES: assert property (@(posedge clock_in)
		disable iff (rst_in)
		bus_in.wr && bus_in.addr == OFS_POWER_CTL
			&& bus_in.wdata[PWR_PD_BIT] |=> ##1 !analog_reg_enable_out)
		else $error("Power-down bit did not disable regulator");

	AST_POWER_ON_BOUND: assert property (p_power_on_bounded)
		else $error("Regulator ready flag late");

	AST_POWER_ON_DELAY: assert property (p_power_on_not_early)
		else $error("Analog regulator enabled too early");

	AST_DIGITAL_SLEEP: assert property (@(posedge clock_in)
		disable iff (rst_in)
		power_mode_in == SLEEP_MODE_THREE |=> !digital_reg_enable_out)
		else $error("Digital regulator on in deep sleep");

endmodule : radio_status_ctl

// [inc/radio_pkg.sv]
// Shared constants and types for the radio status and regulator block
package radio_pkg;

	// ---------------------------------------------------------------
	// Register bus and offsets
	// ---------------------------------------------------------------
	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;
	localparam logic [15:0] OFS_RX_THRESHOLD = 16'hdf4f;
	localparam logic [15:0] OFS_PIN_CFG_A = 16'hdf50;
	localparam logic [15:0] OFS_PIN_CFG_B = 16'hdf51;
	localparam logic [15:0] OFS_PIN_CFG_C = 16'hdf52;
	localparam logic [15:0] OFS_CHIP_REVISION = 16'hdf60;
	localparam logic [15:0] OFS_CHIP_ID = 16'hdf61;
	localparam logic [15:0] OFS_RADIO_STATUS = 16'hdf62;
	localparam logic [15:0] OFS_XTAL_TRIM = 16'hdf63;
	localparam logic [15:0] OFS_IRQ_SRC_EN = 16'hdf64;
	localparam logic [15:0] OFS_POWER_CTL = 16'hdf70;
	localparam logic [15:0] OFS_IRQ_FLAGS = 16'hdf71;

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int ST_TX_ACTIVE = 4;
	localparam int ST_RX_DATA = 3;
	localparam int ST_RX_THRESH = 2;
	localparam int ST_SFD = 1;
	localparam int ST_CCA = 0;
	localparam int CFG_OE_BIT = 6;
	localparam int CFG_POL_BIT = 5;
	localparam int CFG_C_OE_THR = 3;
	localparam int CFG_C_POL_THR = 2;
	localparam int CFG_C_OE_DATA = 1;
	localparam int CFG_C_POL_DATA = 0;
	localparam int PWR_STATUS_BIT = 0;
	localparam int PWR_PD_BIT = 1;
	localparam int PWR_DELAY_LSB = 4;
	localparam int IRQ_ACK_BIT = 0;
	localparam int IRQ_REG_READY_BIT = 1;
	localparam int DBG_RX_DATA = 0;
	localparam int DBG_RX_THRESH = 1;
	localparam int DBG_SFD = 2;
	localparam int DBG_CCA = 3;

	// ---------------------------------------------------------------
	// Reset values
	// ---------------------------------------------------------------
	localparam logic [6:0] RST_THRESHOLD = 7'h40;
	localparam logic [3:0] RST_XTAL_TRIM = 4'hf;
	localparam logic RST_ACK_EN = 1'b0;
	localparam logic RST_POWERDOWN = 1'b1;
	localparam logic [3:0] RST_PWR_DELAY = 4'h3;

	// ---------------------------------------------------------------
	// Timing and power modes
	// ---------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 100;
	localparam int DELAY_STEP_NS = 1000;
	localparam int DELAY_STEP_CYC =
		(DELAY_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [1:0] PM_ACTIVE = 2'h0;
	localparam logic [1:0] PM_ONE = 2'h1;
	localparam logic [1:0] SLEEP_MODE_TWO = 2'h2;
	localparam logic [1:0] SLEEP_MODE_THREE = 2'h3;

	// ---------------------------------------------------------------
	// Types
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {REG_OFF, REG_WAIT, REG_ON} reg_state_t;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} bus_req_t;

	typedef struct packed {
		logic tx_active;
		logic [7:0] rx_count;
		logic filter_en;
		logic frame_passed;
		logic frame_complete;
		logic frame_delimiter_status;
		logic cca;
		logic ack_frame;
	} radio_evt_t;

	typedef struct packed {
		logic [3:0] oe;
		logic [3:0] pol;
	} debug_cfg_t;

	typedef struct packed {
		logic [3:0] level;
		logic [3:0] oe;
	} dbg_pins_t;

endpackage : radio_pkg

// [test/radio_status_ctl_tb.sv]
// Self-checking testbench for the radio status and regulator block
`timescale 1ns/1ns
module radio_status_ctl_tb;
	import radio_pkg::*;

	// ---------------------------------------------------------------
	// Signals and design instance
	// ---------------------------------------------------------------
	logic clock_in = 1'b0;
	logic rst_in = 1'b1;
	bus_req_t bus = '0;
	radio_evt_t radio = '0;
	logic [1:0] power_mode = PM_ACTIVE;
	logic [7:0] rdata;
	dbg_pins_t pins;
	logic [3:0] trim;
	logic analog_en;
	logic digital_en;
	logic [1:0] flags;
	int fail_count = 0;
	int checks = 0;

	always #50 clock_in = ~clock_in;

	radio_status_ctl u_radio_status_ctl (
		.clock_in(clock_in),
		.rst_in(rst_in),
		.bus_in(bus),
		.rdata_out(rdata),
		.radio_in(radio),
		.power_mode_in(power_mode),
		.dbg_pins_out(pins),
		.xtal_trim_out(trim),
		.analog_reg_enable_out(analog_en),
		.digital_reg_enable_out(digital_en),
		.radio_flags_out(flags)
	);

	// ---------------------------------------------------------------
	// Shared tasks
	// ---------------------------------------------------------------
	task automatic check(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic tick(input int n);
		repeat (n) @(posedge clock_in);
		#1;
	endtask : tick

	task automatic bus_wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clock_in);
		bus.addr <= a;
		bus.wdata <= d;
		bus.wr <= 1'b1;
		@(posedge clock_in);
		bus.wr <= 1'b0;
	endtask : bus_wr

	// Counts whole cycles until the analog regulator reports on
	task automatic wait_analog(output int n);
		n = 0;
		while (analog_en !== 1'b1 && n < 200) begin
			tick(1);
			n++;
		end
	endtask : wait_analog

	// Read data stand only in the cycle after the strobe
	task automatic rd_check(input string what, input logic [15:0] a,
		input logic [7:0] exp);
		@(posedge clock_in);
		bus.addr <= a;
		bus.rd <= 1'b1;
		@(posedge clock_in);
		bus.rd <= 1'b0;
		#1;
		check(what, exp, rdata);
	endtask : rd_check

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic reset_values;
		check("trim output", 8'h0f, {4'h0, trim});
		check("digital enable", 8'h01, {7'h0, digital_en});
		check("analog enable", 8'h00, {7'h0, analog_en});
		rd_check("trim reset", OFS_XTAL_TRIM, 8'h0f);
		rd_check("ack enable reset", OFS_IRQ_SRC_EN, 8'h00);
		rd_check("threshold reset", OFS_RX_THRESHOLD, 8'h40);
		rd_check("revision", OFS_CHIP_REVISION, 8'h11);
	endtask : reset_values

	task automatic chip_id_fixed;
		rd_check("chip id", OFS_CHIP_ID, 8'h5a);
		tick(1);
		check("read data cleared", 8'h00, rdata);
		bus_wr(OFS_CHIP_ID, 8'ha5);
		rd_check("chip id after write", OFS_CHIP_ID, 8'h5a);
		rd_check("unmapped read", 16'h0000, 8'h00);
	endtask : chip_id_fixed

	task automatic status_case(input string what, input radio_evt_t e,
		input logic [7:0] exp);
		@(posedge clock_in);
		radio <= e;
		rd_check(what, OFS_RADIO_STATUS, exp);
	endtask : status_case

	task automatic status_bits;
		radio_evt_t e;
		bus_wr(OFS_RX_THRESHOLD, 8'h04);
		e = '0;
		e.tx_active = 1'b1;
		e.rx_count = 8'h04;
		e.frame_delimiter_status = 1'b1;
		e.cca = 1'b1;
		status_case("status at threshold", e, 8'h1b);
		e = '0;
		e.rx_count = 8'h05;
		e.filter_en = 1'b1;
		status_case("status unfiltered", e, 8'h08);
		e.frame_passed = 1'b1;
		status_case("status filtered", e, 8'h0c);
		e = '0;
		e.frame_complete = 1'b1;
		status_case("status frame done", e, 8'h04);
		status_case("status idle", '0, 8'h00);
	endtask : status_bits

	task automatic trim_field;
		bus_wr(OFS_XTAL_TRIM, 8'hf0);
		tick(1);
		check("trim max load", 8'h00, {4'h0, trim});
		rd_check("trim readback", OFS_XTAL_TRIM, 8'h00);
		bus_wr(OFS_XTAL_TRIM, 8'h07);
		rd_check("trim mid", OFS_XTAL_TRIM, 8'h07);
	endtask : trim_field

	task automatic ack_pulse;
		@(posedge clock_in);
		radio.ack_frame <= 1'b1;
		@(posedge clock_in);
		radio.ack_frame <= 1'b0;
		tick(1);
	endtask : ack_pulse

	task automatic ack_irq;
		ack_pulse();
		check("ack flag masked", 8'h00, {7'h0, flags[0]});
		bus_wr(OFS_IRQ_SRC_EN, 8'h01);
		ack_pulse();
		check("ack flag set", 8'h01, {7'h0, flags[0]});
		rd_check("flag register", OFS_IRQ_FLAGS, 8'h01);
		bus_wr(OFS_IRQ_FLAGS, 8'h01);
		tick(1);
		check("ack flag cleared", 8'h00, {7'h0, flags[0]});
		// A clear in the same cycle as a new event must lose
		@(posedge clock_in);
		radio.ack_frame <= 1'b1;
		bus.addr <= OFS_IRQ_FLAGS;
		bus.wdata <= 8'h01;
		bus.wr <= 1'b1;
		@(posedge clock_in);
		radio.ack_frame <= 1'b0;
		bus.wr <= 1'b0;
		tick(1);
		check("ack set beats clear", 8'h01, {7'h0, flags[0]});
		bus_wr(OFS_IRQ_FLAGS, 8'h01);
	endtask : ack_irq

	task automatic debug_pins;
		radio_evt_t e;
		bus_wr(OFS_PIN_CFG_A, 8'h60);
		bus_wr(OFS_PIN_CFG_B, 8'h40);
		bus_wr(OFS_PIN_CFG_C, 8'h0b);
		e = '0;
		e.rx_count = 8'h05;
		e.frame_delimiter_status = 1'b1;
		@(posedge clock_in);
		radio <= e;
		tick(2);
		check("debug pins", 8'hef, pins);
		bus_wr(OFS_PIN_CFG_C, 8'h00);
		bus_wr(OFS_PIN_CFG_A, 8'h00);
		tick(2);
		check("debug pins partial", 8'h74, pins);
		// A nonzero multiplexer setting keeps the pin undriven
		bus_wr(OFS_PIN_CFG_B, 8'h61);
		tick(2);
		check("debug pins sel", 8'h30, pins);
		rd_check("cfg b readback", OFS_PIN_CFG_B, 8'h61);
	endtask : debug_pins

	task automatic regulator;
		int n;
		rd_check("power ctl reset", OFS_POWER_CTL, 8'h33);
		bus_wr(OFS_POWER_CTL, 8'h00);
		rd_check("still powered down", OFS_POWER_CTL, 8'h01);
		check("ready not yet", 8'h00, {7'h0, flags[1]});
		wait_analog(n);
		check("delay one step", 8'(DELAY_STEP_CYC - 1), 8'(n));
		check("analog on", 8'h01, {7'h0, analog_en});
		check("ready flag", 8'h01, {7'h0, flags[1]});
		rd_check("powered up", OFS_POWER_CTL, 8'h00);
		bus_wr(OFS_IRQ_FLAGS, 8'h02);
		bus_wr(OFS_POWER_CTL, 8'h02);
		tick(2);
		check("analog off", 8'h00, {7'h0, analog_en});
		check("ready cleared", 8'h00, {7'h0, flags[1]});
		bus_wr(OFS_POWER_CTL, 8'h10);
		rd_check("delay two set", OFS_POWER_CTL, 8'h11);
		wait_analog(n);
		check("delay two", 8'(2 * DELAY_STEP_CYC - 1), 8'(n));
		check("ready again", 8'h01, {7'h0, flags[1]});
	endtask : regulator

	task automatic sleep_modes;
		for (int pm = 0; pm < 4; pm++) begin
			@(posedge clock_in);
			power_mode <= 2'(pm);
			tick(2);
			check("digital enable", {7'h0, pm < 2}, {7'h0, digital_en});
		end
		rd_check("threshold kept", OFS_RX_THRESHOLD, 8'h04);
		@(posedge clock_in);
		power_mode <= PM_ACTIVE;
		tick(2);
	endtask : sleep_modes

	// ---------------------------------------------------------------
	// Verdict and main sequence
	// ---------------------------------------------------------------
	task automatic wrap_up;
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : wrap_up

	// Whole run is about 160 cycles; this allows 5000, some thirty times that
	initial begin
		#(CLK_PERIOD_NS * 5000);
		fail_count++;
		wrap_up();
	end

	initial begin
		repeat (12) @(posedge clock_in);
		rst_in <= 1'b0;
		tick(1);
		reset_values();
		chip_id_fixed();
		status_bits();
		trim_field();
		ack_irq();
		debug_pins();
		regulator();
		sleep_modes();
		wrap_up();
	end

endmodule : radio_status_ctl_tb
